// ===== hw/gdr_map.svh
// register indices, field masks, reset values and timing counts for the gpio data/direction block
`ifndef GDR_MAP_SVH
`define GDR_MAP_SVH
`define GDR_IDX_LO_OUT 16'hC01E
`define GDR_IDX_LO_IN 16'hC020
`define GDR_IDX_LO_DIR 16'hC022
`define GDR_IDX_UP_OUT 16'hC024
`define GDR_IDX_UP_IN 16'hC026
`define GDR_IDX_UP_DIR 16'hC028
`define GDR_IDX_MODE 16'hC02A
`define GDR_LO_MASK 16'hFFFF
`define GDR_UP_MASK 16'hE1F8
`define GDR_MODE_MASK 16'h0007
`define GDR_RST_LATCH 16'h0000
`define GDR_RST_DIR 16'h0000
`define GDR_RST_MODE 3'h0
`define GDR_MODE_GPIO 3'h0
`define GDR_SYNC_STAGES 2
`endif

// ===== hw/gdr_pkg.sv
// types shared by the gpio data/direction block
package gdr_pkg;
  typedef enum logic [2:0] {
    GDR_SEL_NONE,
    GDR_SEL_LO_OUT,
    GDR_SEL_LO_IN,
    GDR_SEL_LO_DIR,
    GDR_SEL_UP_OUT,
    GDR_SEL_UP_IN,
    GDR_SEL_UP_DIR,
    GDR_SEL_MODE
  } gdr_sel_t;
  typedef logic [2:0] gdr_mode_t;
endpackage : gdr_pkg

// ===== hw/gdr_top.sv
// gpio data and direction registers for two pin banks of 16 and 9 pins, avalon-mm slave
// Operation
// - latch banks drive pins 15:0 and 31:19
// - latch reads return last written value
// - latch one drives high, zero low
// - input banks report pins 15:0 and 31:19
// - input bits show pin level; writes ignored
// - direction banks control pins 15:0, 31:19
// - direction one enables pin driver from latch
// - direction zero releases driver, input only
// - input registers at 0xC020 and 0xC026
// - direction registers at 0xC022 and 0xC028
// - upper latch register at 0xC024
// - pins act as gpio only in mode 000
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/10ps
`include "gdr_map.svh"

module gdr_top
  import gdr_pkg::*;
(
  input wire logic core_clk, // 200 MHz system clock
  input wire logic nrst, // async reset, active low
  input wire logic [15:0] address, // word address, equals register index
  input wire logic read, // avalon read request
  input wire logic write, // avalon write request
  input wire logic [3:0] byteenable, // avalon byte lanes
  input wire logic [31:0] writedata, // avalon write data
  output logic [31:0] readdata, // avalon read data
  output logic waitrequest, // avalon stall
  input wire logic [31:0] pin_in, // pin levels seen at the pads
  output logic [31:0] pin_out, // pin output levels
  output logic [31:0] pin_oe_n // pin driver enable, low drives
);

  logic [15:0] lat_lo_ff;
  logic [15:0] lat_up_ff;
  logic [15:0] dir_lo_ff;
  logic [15:0] dir_up_ff;
  gdr_mode_t mode_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] sync1_ff;
  logic [31:0] sync2_ff;
  logic [15:0] nxt_lat_lo;
  logic [15:0] nxt_lat_up;
  logic [15:0] nxt_dir_lo;
  logic [15:0] nxt_dir_up;
  gdr_mode_t nxt_mode;
  logic nxt_ack;
  logic [31:0] nxt_rdata;
  logic [31:0] nxt_sync1;
  logic [31:0] nxt_sync2;
  gdr_sel_t sel;
  logic req;
  logic wr_go;
  logic [15:0] be_mask;
  logic [15:0] in_lo;
  logic [15:0] in_up;
  logic [31:0] lat_map;
  logic [31:0] dir_map;
  logic gpio_mode;

  // upper bank holds pins 31:29 in bits 15:13 and pins 24:19 in bits 8:3
  function automatic logic [31:0] gdr_to_pins(input logic [15:0] up, input logic [15:0] lo);
    gdr_to_pins = {up[15:13], 4'h0, up[8:3], 3'h0, lo};
  endfunction : gdr_to_pins

  // address decode
  always_comb begin
    unique case (address)
      `GDR_IDX_LO_OUT: sel = GDR_SEL_LO_OUT;
      `GDR_IDX_LO_IN: sel = GDR_SEL_LO_IN;
      `GDR_IDX_LO_DIR: sel = GDR_SEL_LO_DIR;
      `GDR_IDX_UP_OUT: sel = GDR_SEL_UP_OUT;
      `GDR_IDX_UP_IN: sel = GDR_SEL_UP_IN;
      `GDR_IDX_UP_DIR: sel = GDR_SEL_UP_DIR;
      `GDR_IDX_MODE: sel = GDR_SEL_MODE;
      default: sel = GDR_SEL_NONE;
    endcase
  end

  // one wait cycle: read data is captured on the first edge and stands on the second
  assign req = read | write;
  assign waitrequest = req & ~ack_ff;
  assign wr_go = write & ack_ff;
  assign be_mask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
  assign readdata = rdata_ff;

  assign in_lo = sync2_ff[15:0];
  assign in_up = {sync2_ff[31:29], 4'h0, sync2_ff[24:19], 3'h0};

  always_comb begin
    nxt_ack = req & ~ack_ff;
    nxt_rdata = rdata_ff;
    if (read && !ack_ff) begin
      unique case (sel)
        GDR_SEL_LO_OUT: nxt_rdata = {16'h0000, lat_lo_ff};
        GDR_SEL_LO_IN: nxt_rdata = {16'h0000, in_lo};
        GDR_SEL_LO_DIR: nxt_rdata = {16'h0000, dir_lo_ff};
        GDR_SEL_UP_OUT: nxt_rdata = {16'h0000, lat_up_ff};
        GDR_SEL_UP_IN: nxt_rdata = {16'h0000, in_up};
        GDR_SEL_UP_DIR: nxt_rdata = {16'h0000, dir_up_ff};
        GDR_SEL_MODE: nxt_rdata = {29'h00000000, mode_ff};
        GDR_SEL_NONE: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  // register writes; reserved bits are masked so they always read zero
  always_comb begin
    nxt_lat_lo = lat_lo_ff;
    nxt_lat_up = lat_up_ff;
    nxt_dir_lo = dir_lo_ff;
    nxt_dir_up = dir_up_ff;
    nxt_mode = mode_ff;
    if (wr_go) begin
      unique case (sel)
        GDR_SEL_LO_OUT: nxt_lat_lo = (lat_lo_ff & ~be_mask) | (writedata[15:0] & be_mask & `GDR_LO_MASK);
        GDR_SEL_LO_DIR: nxt_dir_lo = (dir_lo_ff & ~be_mask) | (writedata[15:0] & be_mask & `GDR_LO_MASK);
        GDR_SEL_UP_OUT: nxt_lat_up = (lat_up_ff & ~be_mask) | (writedata[15:0] & be_mask & `GDR_UP_MASK);
        GDR_SEL_UP_DIR: nxt_dir_up = (dir_up_ff & ~be_mask) | (writedata[15:0] & be_mask & `GDR_UP_MASK);
        GDR_SEL_MODE: begin
          if (byteenable[0]) begin
            nxt_mode = writedata[2:0];
          end
        end
        GDR_SEL_LO_IN, GDR_SEL_UP_IN, GDR_SEL_NONE: nxt_mode = mode_ff;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lat_lo_ff <= `GDR_RST_LATCH;
      lat_up_ff <= `GDR_RST_LATCH;
      dir_lo_ff <= `GDR_RST_DIR;
      dir_up_ff <= `GDR_RST_DIR;
      mode_ff <= `GDR_RST_MODE;
    end else begin
      lat_lo_ff <= nxt_lat_lo;
      lat_up_ff <= nxt_lat_up;
      dir_lo_ff <= nxt_dir_lo;
      dir_up_ff <= nxt_dir_up;
      mode_ff <= nxt_mode;
    end
  end

  // pads are asynchronous to core_clk; first stage feeds only the second
  assign nxt_sync1 = pin_in;
  assign nxt_sync2 = sync1_ff;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_ff <= 32'h00000000;
      sync2_ff <= 32'h00000000;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  // pin drivers; absent pins 28:25 and 18:16 map to zero and never drive
  assign lat_map = gdr_to_pins(lat_up_ff, lat_lo_ff);
  assign dir_map = gdr_to_pins(dir_up_ff, dir_lo_ff);
  assign gpio_mode = (mode_ff == `GDR_MODE_GPIO);

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_pin
      assign pin_out[gi] = lat_map[gi];
      assign pin_oe_n[gi] = ~(dir_map[gi] & gpio_mode);
    end
  endgenerate

  // checks
  sequence s_wr_lo_out;
    write && ack_ff && address == `GDR_IDX_LO_OUT && byteenable[1:0] == 2'b11;
  endsequence

  sequence s_rd_lo_in;
    // sync stages are held in reset until the edge after release, so skip reads that capture them too early
    read && !ack_ff && address == `GDR_IDX_LO_IN && $past(nrst, 2) && $past(nrst);
  endsequence

  sequence s_wr_input;
    write && ack_ff && (address == `GDR_IDX_LO_IN || address == `GDR_IDX_UP_IN);
  endsequence

  chk_latch_readback: assert property (@(posedge core_clk) disable iff (!nrst)
    s_wr_lo_out |=> (lat_lo_ff == $past(writedata[15:0])) && (pin_out[15:0] == $past(writedata[15:0])))
    else $error("lower latch does not hold written value");

  chk_input_sample: assert property (@(posedge core_clk) disable iff (!nrst)
    s_rd_lo_in |=> readdata[15:0] == $past(pin_in[15:0], 3))
    else $error("lower input read does not show synchronised pin level");

  chk_input_readonly: assert property (@(posedge core_clk) disable iff (!nrst)
    s_wr_input |=> $stable(lat_lo_ff) && $stable(lat_up_ff) && $stable(dir_lo_ff) && $stable(dir_up_ff))
    else $error("write to input register changed state");

  chk_sync_depth: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(nrst, 2) && $past(nrst) |-> in_lo == $past(pin_in[15:0], 2))
    else $error("pin level not delayed by two stages");

  chk_drive_enable: assert property (@(posedge core_clk) disable iff (!nrst)
    (gpio_mode && dir_lo_ff[0]) |-> !pin_oe_n[0] && pin_out[0] == lat_lo_ff[0])
    else $error("output driver not enabled from latch");

  chk_drive_release: assert property (@(posedge core_clk) disable iff (!nrst)
    (pin_oe_n[31:19] | {dir_up_ff[15:13], 4'hF, dir_up_ff[8:3]}) == 13'h1FFF)
    else $error("upper pin driven while direction is input");

  chk_mode_release: assert property (@(posedge core_clk) disable iff (!nrst)
    (mode_ff != `GDR_MODE_GPIO) |-> pin_oe_n == 32'hFFFFFFFF)
    else $error("pins driven outside gpio mode");

  chk_upper_map: assert property (@(posedge core_clk) disable iff (!nrst)
    pin_out[31:29] == lat_up_ff[15:13] && pin_out[24:19] == lat_up_ff[8:3] && pin_oe_n[28:25] == 4'hF)
    else $error("upper latch bank mapped to wrong pins");

  chk_bus_answer: assert property (@(posedge core_clk) disable iff (!nrst)
    (req && waitrequest) |=> !waitrequest)
    else $error("bus answer not given after one wait cycle");

  chk_reset_clear: assert property (@(posedge core_clk)
    $rose(nrst) |-> lat_lo_ff == 16'h0000 && dir_lo_ff == 16'h0000 && dir_up_ff == 16'h0000 && pin_oe_n == 32'hFFFFFFFF)
    else $error("latches or directions not cleared by reset");

  sequence s_wr_up_out;
    write && ack_ff && address == `GDR_IDX_UP_OUT && byteenable[1:0] == 2'b11;
  endsequence

  sequence s_wr_lo_dir;
    write && ack_ff && address == `GDR_IDX_LO_DIR && byteenable[1:0] == 2'b11;
  endsequence

  sequence s_wr_up_dir;
    write && ack_ff && address == `GDR_IDX_UP_DIR && byteenable[1:0] == 2'b11;
  endsequence

  // same reset guard as the lower input read
  sequence s_rd_up_in;
    read && !ack_ff && address == `GDR_IDX_UP_IN && $past(nrst, 2) && $past(nrst);
  endsequence

  chk_upper_readback: assert property (@(posedge core_clk) disable iff (!nrst)
    s_wr_up_out |=> lat_up_ff == ($past(writedata[15:0]) & `GDR_UP_MASK))
    else $error("upper latch does not hold written value");

  chk_lo_dir_write: assert property (@(posedge core_clk) disable iff (!nrst)
    s_wr_lo_dir |=> dir_lo_ff == $past(writedata[15:0]))
    else $error("lower direction does not hold written value");

  chk_up_dir_write: assert property (@(posedge core_clk) disable iff (!nrst)
    s_wr_up_dir |=> dir_up_ff == ($past(writedata[15:0]) & `GDR_UP_MASK))
    else $error("upper direction does not hold written value");

  chk_upper_input: assert property (@(posedge core_clk) disable iff (!nrst)
    s_rd_up_in |=> readdata[15:13] == $past(pin_in[31:29], 3) && readdata[8:3] == $past(pin_in[24:19], 3)
      && readdata[12:9] == 4'h0 && readdata[2:0] == 3'h0)
    else $error("upper input read does not show synchronised pin level");

  chk_lower_map: assert property (@(posedge core_clk) disable iff (!nrst)
    pin_out[15:0] == lat_lo_ff)
    else $error("lower latch bank not driven onto its pins");

  chk_lower_release: assert property (@(posedge core_clk) disable iff (!nrst)
    (pin_oe_n[15:0] | dir_lo_ff) == 16'hFFFF)
    else $error("lower pin driven while direction is input");

  chk_lower_drive: assert property (@(posedge core_clk) disable iff (!nrst)
    gpio_mode |-> pin_oe_n[15:0] == ~dir_lo_ff)
    else $error("lower output driver does not follow direction");

  chk_upper_drive: assert property (@(posedge core_clk) disable iff (!nrst)
    gpio_mode |-> pin_oe_n[31:29] == ~dir_up_ff[15:13] && pin_oe_n[24:19] == ~dir_up_ff[8:3])
    else $error("upper output driver does not follow direction");

  chk_absent_pins: assert property (@(posedge core_clk) disable iff (!nrst)
    pin_oe_n[28:25] == 4'hF && pin_oe_n[18:16] == 3'h7 && pin_out[28:25] == 4'h0 && pin_out[18:16] == 3'h0)
    else $error("absent pin driven");

  chk_reserved_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    (lat_up_ff & ~`GDR_UP_MASK) == 16'h0000 && (dir_up_ff & ~`GDR_UP_MASK) == 16'h0000)
    else $error("upper bank reserved bit stored");

  chk_read_upper_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    readdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");

  chk_sync_stage2: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(nrst) |-> sync2_ff == $past(sync1_ff))
    else $error("second sync stage does not follow the first");

endmodule : gdr_top

// ===== testbench/gdr_pin_model.sv
// board side of the gpio pads: drives its own pattern wherever the device lets go
`timescale 1ns/10ps

module gdr_pin_model (
  input wire logic [31:0] pin_out, // device output levels
  input wire logic [31:0] pin_oe_n, // device driver enable, low drives
  input wire logic [31:0] board_val, // level the board puts on released pads
  output logic [31:0] pin_in // resolved pad level
);
  // a driven pad reads back the device's level, a released one the board's
  assign pin_in = (pin_out & ~pin_oe_n) | (board_val & pin_oe_n);
endmodule : gdr_pin_model

// ===== testbench/gdr_top_tb.sv
// self-checking bench for the gpio data/direction registers
`timescale 1ns/10ps
`include "gdr_map.svh"

module gdr_top_tb;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [15:0] address = 16'h0000;
  logic [3:0] byteenable = 4'h0;
  logic [3:0] be_sel = 4'hF;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] board_val = 32'h00000000;
  logic [31:0] readdata, pin_in, pin_out, pin_oe_n;
  logic waitrequest;
  logic [15:0] a;
  int num_errors = 0;
  int n_compared = 0;

  always #2.5 core_clk = ~core_clk;

  gdr_top dut (.core_clk(core_clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  gdr_pin_model board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .board_val(board_val), .pin_in(pin_in));

  // upper register bits 15:13 and 8:3 sit on pads 31:29 and 24:19
  function automatic logic [31:0] pins(input logic [15:0] up, input logic [15:0] lo);
    return {up[15:13], 4'h0, up[8:3], 3'h0, lo};
  endfunction : pins

  function automatic logic [15:0] fold(input logic [31:0] p);
    return {p[31:29], 4'h0, p[24:19], 3'h0};
  endfunction : fold

  task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : cmp

  // one avalon transfer; the request stands until waitrequest is seen low
  task automatic acc(input logic is_rd, input logic [15:0] ad, input logic [15:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    read <= is_rd;
    write <= !is_rd;
    address <= ad;
    writedata <= {16'h0000, d};
    byteenable <= be_sel;
    @(posedge core_clk);
    while (waitrequest !== 1'b0 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 20) num_errors++;
    // outputs are read here before this edge updates them
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : acc

  task automatic wr(input logic [15:0] ad, input logic [15:0] d);
    logic [31:0] q;
    acc(1'b0, ad, d, q);
  endtask : wr

  task automatic rd(input logic [15:0] ad, input logic [15:0] exp);
    logic [31:0] q;
    acc(1'b1, ad, 16'h0000, q);
    cmp({16'h0000, exp}, q);
  endtask : rd

  task automatic do_reset;
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
  endtask : do_reset

  task automatic results;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  initial begin
    repeat (3000) @(posedge core_clk);
    num_errors++;
    results;
  end

  initial begin
    do_reset;
    for (a = `GDR_IDX_LO_OUT; a <= `GDR_IDX_MODE; a = a + 16'h0002) rd(a, 16'h0000);
    rd(16'hC030, 16'h0000);
    cmp(32'hFFFFFFFF, pin_oe_n);
    // reserved positions are always written as zero
    wr(`GDR_IDX_LO_OUT, 16'hA5C3);
    wr(`GDR_IDX_UP_OUT, 16'hA1A8);
    board_val <= 32'h5E1B3C96;
    repeat (4) @(posedge core_clk);
    rd(`GDR_IDX_LO_OUT, 16'hA5C3);
    rd(`GDR_IDX_UP_OUT, 16'hA1A8);
    rd(`GDR_IDX_LO_IN, 16'h3C96);
    rd(`GDR_IDX_UP_IN, fold(32'h5E1B3C96));
    wr(`GDR_IDX_LO_IN, 16'h0000);
    wr(`GDR_IDX_UP_IN, 16'h0000);
    rd(`GDR_IDX_LO_IN, 16'h3C96);
    rd(`GDR_IDX_UP_IN, fold(32'h5E1B3C96));
    wr(`GDR_IDX_LO_DIR, 16'hFFFF);
    wr(`GDR_IDX_UP_DIR, 16'hE1F8);
    @(negedge core_clk);
    cmp(~pins(16'hE1F8, 16'hFFFF), pin_oe_n);
    cmp(pins(16'hA1A8, 16'hA5C3), pin_out);
    rd(`GDR_IDX_LO_DIR, 16'hFFFF);
    rd(`GDR_IDX_UP_DIR, 16'hE1F8);
    rd(`GDR_IDX_LO_IN, 16'hA5C3);
    rd(`GDR_IDX_UP_IN, 16'hA1A8);
    be_sel = 4'h1;
    wr(`GDR_IDX_LO_OUT, 16'h3C5A);
    be_sel = 4'hF;
    rd(`GDR_IDX_LO_OUT, 16'hA55A);
    wr(`GDR_IDX_MODE, 16'h0001);
    @(negedge core_clk);
    cmp(32'hFFFFFFFF, pin_oe_n);
    wr(`GDR_IDX_MODE, 16'h0000);
    @(negedge core_clk);
    cmp(~pins(16'hE1F8, 16'hFFFF), pin_oe_n);
    do_reset;
    rd(`GDR_IDX_LO_OUT, 16'h0000);
    rd(`GDR_IDX_UP_DIR, 16'h0000);
    cmp(32'hFFFFFFFF, pin_oe_n);
    results;
  end
endmodule : gdr_top_tb
